// ==== logic/vecr_regs.svh ====
// register offsets, field positions, reset values and codes of the control bank
// Summary of operation
// RULE1: answer only address 0010101 as a write-only slave receiver.
// RULE2: master sends start, address, subaddress, data bytes, stop; each acked.
// RULE3: register pointer advances after every data byte; the code holds it at ff instead of wrapping.
// RULE4: mode bits 7-6 pick normal, multi, still-in, picture-in; bit 5 border.
// RULE5: mode bit 4 has no function and is held at zero.
// RULE6: bit 3 set bypasses noise filtering on half the screen.
// RULE7: bit 2 tape source, bit 1 filter on, bit 0 eight-bit chroma.
// RULE8: subaddress 01 bits 7-5 give border brightness, black to white.
// RULE9: subaddress 01 bits 4-0 lower class limit, reset 4.
// RULE10: subaddress 02 bits 4-0 upper class limit, reset 16.
// RULE11: subaddress 02 bits 7-5 pick measurement line 4,0,1,2,3,5,7.
// RULE12: test bit 7 forces class 0, 1 or 2 from bits 6-5.
// RULE13: test bit 4 forces filter coefficient K from bits 3-0.
// RULE14: in multi mode, new mode applies only in vsync high with request.
// RULE15: master writes mode here first, memory controller within 30 ms.
// RULE16: power-on reset loads defaults; test codes ignored unless forced.
// RULE17: output repack restores quasi-parallel or parallel sixteen-line data.
// RULE18: input and output layout pins pick 4:1:1 low, 4:2:2 high.
// RULE19: memory controller request starts transfer and gates mode switching.
// RULE20: bytes past subaddress 03 are acked but ignored; line code 111 reserved.
`ifndef VECR_REGS_SVH
`define VECR_REGS_SVH
`define VECR_SLAVE_ADDR 7'h15
`define VECR_OFS_MODE 8'h00
`define VECR_OFS_BORDER 8'h01
`define VECR_OFS_LINE 8'h02
`define VECR_OFS_TEST 8'h03
`define VECR_RST_MODE 8'h00
`define VECR_RST_BORDER 8'h04
`define VECR_RST_LINE 8'h10
`define VECR_RST_TEST 8'h00
`define VECR_MODE_WMASK 8'hef
`define VECR_BIT_SPLIT 3
`define VECR_BIT_TAPE 2
`define VECR_BIT_FILTER 1
`define VECR_BIT_WIDTH8 0
`define VECR_BIT_BORDER 5
`define VECR_BIT_CLASS_EN 7
`define VECR_BIT_COEF_EN 4
`define VECR_LINE_RSVD 3'h7
`define VECR_CLASS_RSVD 2'h3
`define VECR_BITS_PER_BYTE 4'h8
`define VECR_PTR_MAX 8'hff
`define VECR_MASTER_GAP_MS 30
`endif

// ==== logic/vecr_pkg.sv ====
// types shared by the control bank
package vecr_pkg;
    // serial receiver states, gray coded along the write path
    typedef enum logic [2:0] {
        VECR_IDLE = 3'b000,
        VECR_ADDR = 3'b001,
        VECR_ACK_A = 3'b011,
        VECR_SUB = 3'b010,
        VECR_ACK_S = 3'b110,
        VECR_DATA = 3'b111,
        VECR_ACK_D = 3'b101
    } vecr_state_t;
    typedef enum logic [1:0] {
        VECR_NORMAL = 2'b00,
        VECR_MULTI = 2'b01,
        VECR_STILL_IN = 2'b10,
        VECR_PIC_IN = 2'b11
    } vecr_mode_t;
endpackage

// ==== logic/vecr_sync.sv ====
// two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
`default_nettype none
module vecr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock, // core clock
    input wire logic arst_n, // async reset, low
    input wire logic [WIDTH-1:0] din, // asynchronous levels
    output logic [WIDTH-1:0] dout // synchronised levels
);
    logic [WIDTH-1:0] meta;
    // first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== logic/vecr_ctrl.sv ====
// control register bank with serial slave receiver, mode switch and repack
`timescale 1ns/10ps
`default_nettype none
`include "vecr_regs.svh"
module vecr_ctrl import vecr_pkg::*; (
    input wire logic clock, // 40 MHz core clock
    input wire logic arst_n, // async reset, low
    input wire logic scl, // serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe_n, // low while pulling data low
    input wire logic vertical_sync_in, // high in vertical blanking
    input wire logic memctl_request, // memory controller request
    input wire logic input_layout_select, // low 4:1:1, high 4:2:2
    input wire logic output_layout_select, // low 4:1:1, high 4:2:2
    input wire logic pix_valid, // pixel strobe from datapath
    input wire logic [7:0] pix_luma, // processed luma
    input wire logic [7:0] pix_u, // processed u
    input wire logic [7:0] pix_v, // processed v
    output logic [1:0] mode_code, // applied operating mode
    output logic narrow_border_on, // border around reduced pictures
    output logic split_screen_on, // half screen unfiltered
    output logic tape_source_select, // tape source
    output logic noise_filter_on, // noise reduction enabled
    output logic chroma_width_8, // 8-bit input words
    output logic auto_adapt_on, // automatic class adaptation
    output logic [2:0] border_brightness, // 0 black .. 7 white
    output logic [4:0] lower_class_limit, // lower limit
    output logic [4:0] upper_class_limit, // upper limit
    output logic [2:0] measure_line, // decoded measurement line
    output logic class_forced, // class forced
    output logic [1:0] forced_class, // forced class value
    output logic coef_forced, // coefficient forced
    output logic [4:0] coef_k16, // forced K in sixteenths
    output logic transfer_start, // one-cycle transfer start
    output logic input_422, // input layout 4:2:2
    output logic output_422, // output layout 4:2:2
    output logic [7:0] luma_out, // luma output lines
    output logic [7:0] chroma_out, // chroma output lines
    output logic out_valid // output lines updated
);
    logic [5:0] sync_q;
    logic scl_s, sda_s, vs_s, req_s, scl_d, sda_d, req_d;
    logic start_c, stop_c, scl_rise, scl_fall, byte_done, wr_evt, apply;
    vecr_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg, ptr;
    logic [7:0] mode_reg, border_reg, line_reg, test_reg, mode_active;
    logic pending, req_seen;
    logic [1:0] phase;
    logic [7:0] hold_u, hold_v, src_u, src_v;
    logic [2:0] sel;

    vecr_sync #(.WIDTH(6)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .din({scl, sda_in, vertical_sync_in, memctl_request,
              input_layout_select, output_layout_select}),
        .dout(sync_q)
    );
    assign scl_s = sync_q[5];
    assign sda_s = sync_q[4];
    assign vs_s = sync_q[3];
    assign req_s = sync_q[2];

    // delayed copies for edge finding; reset level matches the
    // synchroniser's so no false scl fall follows reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_d <= 1'b0;
            sda_d <= 1'b0;
            req_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            req_d <= req_s;
        end
    end

    // bus conditions seen at the core clock
    assign start_c = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign byte_done = scl_fall && (cnt == `VECR_BITS_PER_BYTE);
    assign wr_evt = byte_done && (state == VECR_DATA);

    // slave receiver; never drives data for a read
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= VECR_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
        end else if (stop_c) begin
            state <= VECR_IDLE;
            sda_oe_n <= 1'b1;
        end else if (start_c) begin
            state <= VECR_ADDR;
            cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else begin
            unique case (state)
                VECR_IDLE: begin
                    cnt <= 4'h0;
                end
                VECR_ADDR, VECR_SUB, VECR_DATA: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end else if (byte_done) begin
                        sda_oe_n <= 1'b0;
                        if (state == VECR_ADDR) begin
                            if (shreg == {`VECR_SLAVE_ADDR, 1'b0}) begin // RULE1
                                state <= VECR_ACK_A;
                            end else begin
                                state <= VECR_IDLE;
                                sda_oe_n <= 1'b1;
                            end
                        end else if (state == VECR_SUB) begin
                            ptr <= shreg;
                            state <= VECR_ACK_S;
                        end else begin
                            // pointer parks at top so it never wraps to 00
                            if (ptr != `VECR_PTR_MAX) begin
                                ptr <= ptr + 8'h01; // RULE3
                            end
                            state <= VECR_ACK_D;
                        end
                    end
                end
                VECR_ACK_A, VECR_ACK_S, VECR_ACK_D: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b1;
                        cnt <= 4'h0;
                        state <= (state == VECR_ACK_A) ? VECR_SUB : VECR_DATA;
                    end
                end
                default: begin
                    state <= VECR_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // register writes; offsets past 03 are acked but dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= `VECR_RST_MODE; // RULE16
            border_reg <= `VECR_RST_BORDER; // RULE9
            line_reg <= `VECR_RST_LINE; // RULE10
            test_reg <= `VECR_RST_TEST;
        end else if (wr_evt) begin
            case (ptr)
                `VECR_OFS_MODE: mode_reg <= shreg & `VECR_MODE_WMASK; // RULE5
                `VECR_OFS_BORDER: border_reg <= shreg;
                `VECR_OFS_LINE: line_reg <= shreg;
                `VECR_OFS_TEST: test_reg <= shreg;
                default: begin
                end // RULE20
            endcase
        end
    end

    // mode switch: in multi mode wait for blanking plus a request
    assign apply = pending && ((mode_active[7:6] != VECR_MULTI) ||
                   (vs_s && (req_s || req_seen))); // RULE14 RULE19
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pending <= 1'b0;
            req_seen <= 1'b0;
            mode_active <= `VECR_RST_MODE;
        end else begin
            // a fresh write wins over the apply in the same cycle
            if (wr_evt && ptr == `VECR_OFS_MODE) begin
                pending <= 1'b1;
            end else if (apply) begin
                pending <= 1'b0;
            end
            if (apply) begin
                mode_active <= mode_reg;
            end
            req_seen <= vs_s && (req_s || req_seen);
        end
    end

    // line code lookup; 111 is reserved
    function automatic logic [2:0] line_lut(input logic [2:0] code);
        logic [2:0] v;
        case (code)
            3'h0: v = 3'h4;
            3'h1: v = 3'h0;
            3'h2: v = 3'h1;
            3'h3: v = 3'h2;
            3'h4: v = 3'h3;
            3'h5: v = 3'h5;
            default: v = 3'h7;
        endcase
        return v;
    endfunction

    // coefficient lookup in sixteenths
    function automatic logic [4:0] coef_lut(input logic [3:0] code);
        logic [4:0] k;
        case (code)
            4'h0: k = 5'h10;
            4'h1, 4'h4: k = 5'h0c;
            4'h2, 4'h8: k = 5'h0a;
            4'h3, 4'hc: k = 5'h09;
            4'h5: k = 5'h08;
            4'h6, 4'h9: k = 5'h06;
            4'h7, 4'hd: k = 5'h05;
            4'ha: k = 5'h04;
            4'hb, 4'he: k = 5'h03;
            default: k = 5'h02;
        endcase
        return k;
    endfunction

    // decoded control outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_code <= 2'h0;
            narrow_border_on <= 1'b0;
            split_screen_on <= 1'b0;
            tape_source_select <= 1'b0;
            noise_filter_on <= 1'b0;
            chroma_width_8 <= 1'b0;
            auto_adapt_on <= 1'b1;
            border_brightness <= 3'h0;
            lower_class_limit <= 5'h04;
            upper_class_limit <= 5'h10;
            measure_line <= 3'h4;
            class_forced <= 1'b0;
            forced_class <= 2'h0;
            coef_forced <= 1'b0;
            coef_k16 <= 5'h10;
        end else begin
            mode_code <= mode_active[7:6]; // RULE4
            narrow_border_on <= mode_active[`VECR_BIT_BORDER]; // RULE4
            split_screen_on <= mode_active[`VECR_BIT_SPLIT]; // RULE6
            tape_source_select <= mode_active[`VECR_BIT_TAPE]; // RULE7
            noise_filter_on <= mode_active[`VECR_BIT_FILTER]; // RULE7
            chroma_width_8 <= mode_active[`VECR_BIT_WIDTH8]; // RULE7
            auto_adapt_on <= !mode_active[`VECR_BIT_TAPE] &&
                             !test_reg[`VECR_BIT_CLASS_EN]; // RULE7
            border_brightness <= border_reg[7:5]; // RULE8
            lower_class_limit <= border_reg[4:0]; // RULE9
            upper_class_limit <= line_reg[4:0]; // RULE10
            if (line_reg[7:5] != `VECR_LINE_RSVD) begin
                measure_line <= line_lut(line_reg[7:5]); // RULE11 RULE20
            end
            class_forced <= test_reg[`VECR_BIT_CLASS_EN] &&
                            test_reg[6:5] != `VECR_CLASS_RSVD; // RULE12
            forced_class <= test_reg[`VECR_BIT_CLASS_EN] ?
                            test_reg[6:5] : 2'h0; // RULE16
            coef_forced <= test_reg[`VECR_BIT_COEF_EN]; // RULE13
            coef_k16 <= test_reg[`VECR_BIT_COEF_EN] ?
                        coef_lut(test_reg[3:0]) : 5'h10; // RULE13
        end
    end

    // request edge starts a transfer in multi mode only; layout pins pass through
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            transfer_start <= 1'b0;
            input_422 <= 1'b0;
            output_422 <= 1'b0;
        end else begin
            transfer_start <= req_s && !req_d &&
                              mode_active[7:6] == VECR_MULTI; // RULE19
            input_422 <= sync_q[1]; // RULE18
            output_422 <= sync_q[0]; // RULE18
        end
    end

    // quasi-parallel chroma: two bits of u and v per pixel over four pixels
    assign src_u = (phase == 2'h0) ? pix_u : hold_u;
    assign src_v = (phase == 2'h0) ? pix_v : hold_v;
    assign sel = 3'h7 - {phase, 1'b0};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
            hold_u <= 8'h00;
            hold_v <= 8'h00;
            luma_out <= 8'h00;
            chroma_out <= 8'h00;
            out_valid <= 1'b0;
        end else begin
            out_valid <= pix_valid;
            if (pix_valid) begin
                phase <= phase + 2'h1;
                luma_out <= pix_luma; // RULE17
                if (phase == 2'h0) begin
                    hold_u <= pix_u;
                    hold_v <= pix_v;
                end
                if (output_422) begin
                    chroma_out <= phase[0] ? pix_v : pix_u; // RULE17 RULE18
                end else begin
                    chroma_out <= {src_u[sel -: 2], src_v[sel -: 2], 4'h0};
                end
            end
        end
    end

    default clocking vecr_cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    addr_reject_a: assert property (byte_done && state == VECR_ADDR && // RULE1
        shreg != {`VECR_SLAVE_ADDR, 1'b0} |=> state == VECR_IDLE && sda_oe_n)
        else $error("foreign address was acknowledged");
    ptr_advance_a: assert property (wr_evt && ptr < 8'h10 // RULE3
        |=> ptr == $past(ptr) + 8'h01) else $error("pointer did not advance");
    bit4_zero_a: assert property (mode_reg[4] == 1'b0) // RULE5
        else $error("mode bit 4 not zero");
    line_dec_a: assert property (line_reg[7:5] == 3'h5 // RULE11
        |=> measure_line == 3'h5) else $error("line decode wrong");
    coef_dec_a: assert property (test_reg[4:0] == 5'h1f // RULE13
        |=> coef_k16 == 5'h02 && coef_forced) else $error("coef decode wrong");
    mode_gate_a: assert property ($past(mode_active[7:6]) == VECR_MULTI && // RULE14
        mode_active != $past(mode_active) |->
        $past(vs_s) && ($past(req_s) || $past(req_seen)))
        else $error("multi mode switched outside blanking");
    class_auto_a: assert property (!test_reg[7] |=> !class_forced && // RULE12
        forced_class == 2'h0) else $error("class forced while off");
    beyond_top_a: assert property (wr_evt && ptr > 8'h03 |=> // RULE20
        $stable(mode_reg) && $stable(border_reg) && $stable(line_reg) &&
        $stable(test_reg)) else $error("write past 03 changed a register");
    tape_adapt_a: assert property (mode_active[2] |=> !auto_adapt_on) // RULE7
        else $error("adaptation left on for tape");
    ack_low_a: assert property (state == VECR_ACK_D && !scl_fall // RULE2
        |-> !sda_oe_n) else $error("data byte not acknowledged");

    write_mode_c: cover property (wr_evt && ptr == `VECR_OFS_MODE);
    burst_c: cover property (wr_evt && ptr == `VECR_OFS_TEST);
    multi_apply_c: cover property (apply && mode_active[7:6] == VECR_MULTI);
    start_c_c: cover property (transfer_start);
endmodule
`default_nettype wire

// ==== tb/vecr_master.sv ====
// two-wire bus master model that programs the control bank
`timescale 1ns/10ps
`default_nettype none
module vecr_master (
    input wire logic clock, // core clock, paces the bus phases
    input wire logic sda_line, // resolved data line level
    output logic scl, // serial clock, high and still when idle
    output logic sda_drv // 0 pulls data low, 1 releases it
);
    // idle bus: both lines released, clock stands high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // every move lands just after a core clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // start: data falls while the clock is high
    task automatic bus_start();
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    // stop: data rises while the clock is high
    task automatic bus_stop();
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
    // one byte msb first, then a released ninth clock for the ack
    // half periods of 4 core clocks give the 200 ns bus clock
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(2);
            sda_drv = b[i];
            tick(2);
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
        end
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        ack = ~sda_line;
        tick(2);
        scl = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_vecr_ctrl.sv ====
// self-checking bench for the control register bank
`timescale 1ns/10ps
`default_nettype none
module test_vecr_ctrl;
    logic clock, arst_n, scl, sda_drv, sda_in, sda_out, sda_oe_n;
    logic vertical_sync_in, memctl_request, pix_valid, out_valid;
    logic input_layout_select, output_layout_select, input_422, output_422;
    logic [7:0] pix_luma, pix_u, pix_v, luma_out, chroma_out;
    logic [1:0] mode_code, forced_class;
    logic narrow_border_on, split_screen_on, tape_source_select;
    logic noise_filter_on, chroma_width_8, auto_adapt_on, class_forced;
    logic coef_forced, transfer_start, seen;
    logic [2:0] border_brightness, measure_line;
    logic [4:0] lower_class_limit, upper_class_limit, coef_k16;
    logic [7:0] dat [5];
    logic [2:0] lt [8] = '{3'h5, 3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    logic [7:0] qp [4] = '{8'hc0, 8'h30, 8'h30, 8'hc0};
    logic [4:0] kt [16] = '{5'h10, 5'h0c, 5'h0a, 5'h09, 5'h0c, 5'h08,
        5'h06, 5'h05, 5'h0a, 5'h06, 5'h04, 5'h03, 5'h09, 5'h05, 5'h03, 5'h02};
    int num_errors = 0;
    int check_count = 0;
    // open-drain data line with pull-up: low if either side pulls
    assign sda_in = sda_drv & (sda_oe_n | sda_out);
    vecr_ctrl vecr_ctrl_inst (.clock, .arst_n, .scl, .sda_in, .sda_out,
        .sda_oe_n, .vertical_sync_in, .memctl_request, .input_layout_select,
        .output_layout_select, .pix_valid, .pix_luma, .pix_u, .pix_v,
        .mode_code, .narrow_border_on, .split_screen_on, .tape_source_select,
        .noise_filter_on, .chroma_width_8, .auto_adapt_on, .border_brightness,
        .lower_class_limit, .upper_class_limit, .measure_line, .class_forced,
        .forced_class, .coef_forced, .coef_k16, .transfer_start, .input_422,
        .output_422, .luma_out, .chroma_out, .out_valid);
    vecr_master vecr_master_inst (.clock, .sda_line(sda_in), .scl, .sda_drv);
    // 40 MHz core clock
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one telegram: address, subaddress, then n bytes from dat
    task automatic wr(input logic [7:0] sub, input int n);
        logic a;
        vecr_master_inst.bus_start();
        vecr_master_inst.put_byte(8'h2a, a);
        chk({7'h0, a}, 8'h01);
        vecr_master_inst.put_byte(sub, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            vecr_master_inst.put_byte(dat[i], a);
            chk({7'h0, a}, 8'h01);
        end
        vecr_master_inst.bus_stop();
    endtask
    // foreign address or read request, followed by bytes that must not land
    task automatic bad(input logic [7:0] ab);
        logic a;
        vecr_master_inst.bus_start();
        vecr_master_inst.put_byte(ab, a);
        chk({7'h0, a}, 8'h00);
        vecr_master_inst.put_byte(8'h00, a);
        vecr_master_inst.put_byte(8'h00, a);
        vecr_master_inst.bus_stop();
    endtask
    // bounded wait for the applied mode; running out ends the run
    task automatic wait_mode(input logic [1:0] exp);
        for (int i = 0; i < 40 && mode_code !== exp; i++) tick(1);
        chk({6'h0, mode_code}, {6'h0, exp});
        if (mode_code !== exp) wrap_up();
    endtask
    function automatic logic [7:0] mode_bits();
        return {mode_code, narrow_border_on, 1'b0, split_screen_on,
            tape_source_select, noise_filter_on, chroma_width_8};
    endfunction
    initial begin
        arst_n = 1'b0;
        vertical_sync_in = 1'b0;
        memctl_request = 1'b0;
        input_layout_select = 1'b0;
        output_layout_select = 1'b0;
        pix_valid = 1'b0;
        pix_luma = 8'h00;
        pix_u = 8'h00;
        pix_v = 8'h00;
        repeat (20) @(posedge clock);
        #1;
        arst_n = 1'b1;
        tick(4);
        // defaults after power-on reset
        chk(mode_bits(), 8'h00);
        chk({border_brightness, lower_class_limit}, 8'h04);
        chk({measure_line, upper_class_limit}, 8'h90);
        chk({3'h0, coef_k16}, 8'h10);
        chk({auto_adapt_on, class_forced, forced_class, coef_forced,
            out_valid, input_422, output_422}, 8'h80);
        // burst over all four registers and one byte past the end
        dat = '{8'hbf, 8'he7, 8'hbf, 8'h9b, 8'h55};
        wr(8'h00, 5);
        tick(4);
        chk(mode_bits(), 8'haf);
        chk({border_brightness, lower_class_limit}, 8'he7);
        chk({measure_line, upper_class_limit}, 8'hbf);
        chk({3'h0, coef_k16}, 8'h03);
        chk({auto_adapt_on, class_forced, forced_class}, 8'h04);
        bad(8'h2c);
        bad(8'h2b);
        chk(mode_bits(), 8'haf);
        // every line code; reserved 111 first must keep line 5 from the burst
        for (int c = 0; c < 8; c++) begin
            dat[0] = {c[2:0] - 3'h1, 5'h0a};
            wr(8'h02, 1);
            tick(4);
            chk({measure_line, upper_class_limit}, {lt[c], 5'h0a});
        end
        // every coefficient code, class codes cycled alongside
        for (int k = 0; k < 16; k++) begin
            dat[0] = {1'b1, k[1:0], 1'b1, k[3:0]};
            wr(8'h03, 1);
            tick(4);
            chk({3'h0, coef_k16}, {3'h0, kt[k]});
            chk({7'h0, class_forced}, {7'h0, k[1:0] != 2'h3});
            if (k[1:0] != 2'h3) chk({6'h0, forced_class}, {6'h0, k[1:0]});
        end
        // force bits clear: the codes beside them are ignored
        dat[0] = 8'h6f;
        wr(8'h03, 1);
        tick(4);
        chk({class_forced, coef_forced, 1'b0, coef_k16}, 8'h10);
        // into multi-picture is immediate; request starts a transfer
        dat[0] = 8'h40;
        wr(8'h00, 1);
        wait_mode(2'h1);
        memctl_request = 1'b1;
        seen = 1'b0;
        repeat (10) begin
            tick(1);
            seen |= transfer_start;
        end
        chk({7'h0, seen}, 8'h01);
        memctl_request = 1'b0;
        // leaving multi waits for blanking plus a request
        dat[0] = 8'h80;
        wr(8'h00, 1);
        tick(20);
        chk({6'h0, mode_code}, 8'h01);
        vertical_sync_in = 1'b1;
        tick(20);
        chk({6'h0, mode_code}, 8'h01);
        memctl_request = 1'b1;
        wait_mode(2'h2);
        vertical_sync_in = 1'b0;
        memctl_request = 1'b0;
        // layout pins and 4:2:2 repacking, two pixels back to back
        input_layout_select = 1'b1;
        output_layout_select = 1'b1;
        tick(4);
        chk({6'h0, input_422, output_422}, 8'h03);
        pix_valid = 1'b1;
        pix_luma = 8'h5a;
        pix_u = 8'h3c;
        pix_v = 8'hc3;
        tick(1);
        chk(luma_out, 8'h5a);
        chk(chroma_out, 8'h3c);
        pix_luma = 8'ha5;
        tick(1);
        pix_valid = 1'b0;
        chk(luma_out, 8'ha5);
        chk(chroma_out, 8'hc3);
        chk({7'h0, out_valid}, 8'h01);
        tick(1);
        chk({7'h0, out_valid}, 8'h00);
        // 4:1:1 output: group goes on at strobe 3 with u 3c, v c3 held
        output_layout_select = 1'b0;
        tick(4);
        chk({6'h0, input_422, output_422}, 8'h02);
        pix_valid = 1'b1;
        for (int p = 0; p < 4; p++) begin
            tick(1);
            chk(chroma_out, qp[p]);
        end
        pix_valid = 1'b0;
        wrap_up();
    end
endmodule
`default_nettype wire
